// ===== oam_pdu_validation_defines.vh
// Offsets, field positions, codes and reset values of the OAM PDU validation stage
`ifndef OAM_PDU_VALIDATION_DEFINES_VH
`define OAM_PDU_VALIDATION_DEFINES_VH
// Register word indexes (byte address = index * 4)
`define REG_CTRL 6'h00
`define REG_EXTRACT 6'h01
`define REG_STICKY 6'h02
`define REG_IRQ_EN 6'h03
`define REG_LAST 6'h04
`define REG_RX_DISCARD 6'h05
`define REG_TX_DISCARD 6'h06
`define REG_LEVEL_DISCARD 6'h07
`define REG_GROUP_ID_ERR 6'h08
`define REG_ENDPOINT_ID_ERR 6'h09
`define REG_PERIOD_ERR 6'h0A
`define REG_VERSION 6'h0B
`define REG_MC_MAC_LSB 6'h0C
`define REG_MC_MAC_MSB 6'h0D
`define REG_UC_MAC_LSB 6'h0E
`define REG_UC_MAC_MSB 6'h0F
`define REG_GROUP_ID_BASE 6'h10
`define GROUP_ID_WORDS 12
// Control register fields
`define CTRL_LEVEL_LSB 0
`define CTRL_BLOCK_HIGH 3
`define CTRL_DMAC_SEL 4
`define CTRL_VERSION_EN 5
`define CTRL_CONT_ONLY 6
`define CTRL_CCM_EN 7
`define CTRL_GROUP_ID_EN 8
`define CTRL_ENDPOINT_ID_EN 9
`define CTRL_PERIOD_LSB 10
`define CTRL_PRIORITY_LSB 13
`define CTRL_PEER_ID_LSB 16
`define CTRL_RESET 32'h0000_0000
// Event bit positions, shared by last-result, sticky, extract and irq-enable registers
`define EV_ZERO_PERIOD 0
`define EV_LOW_LEVEL 1
`define EV_GROUP_ID 2
`define EV_ENDPOINT_ID 3
`define EV_PERIOD 4
`define EV_PRIORITY 5
`define EV_TX_BLOCK 6
`define EV_HIGH_BLOCK 7
`define EV_LOW_BLOCK 8
`define EV_DEST_MAC 9
`define EV_VERSION 10
`define EV_EXTRA_TLV 11
`define EV_WIDTH 12
`define LAST_WIDTH 6
// Frame kinds carried in frame_kind_field
`define KIND_DATA 2'h0
`define KIND_Y1731 2'h1
`define KIND_SEQ 2'h2
// Opcodes
`define OP_CCM 8'h01
`define OP_LBR 8'h02
`define OP_LBM 8'h03
`define OP_AIS 8'h21
`define OP_LCK 8'h23
`define OP_TST 8'h25
`define OP_LMR 8'h2A
`define OP_LMM 8'h2B
`define OP_1DM 8'h2D
`define OP_DMR 8'h2E
`define OP_DMM 8'h2F
`define OP_1SL 8'h35
`define OP_SLR 8'h36
`define OP_SLM 8'h37
// Version classes: four accepted-version bits per class
`define CLS_CCM 3'h0
`define CLS_LB 3'h1
`define CLS_ALARM 3'h2
`define CLS_TST 3'h3
`define CLS_LM 3'h4
`define CLS_DM 3'h5
`define CLS_SL 3'h6
`define CLS_NONE 3'h7
`define VERSION_RESET 32'h0111_1111
`endif

// ===== oam_pdu_validation.v
// OAM endpoint PDU validation stage with APB register slave
// Behaviour
// - Level bypass flag forces the frame to be handled as data, no checks.
// - Transmit: only Y.1731 kind is validated; sequence numbering and others are data.
// - Transmit reject counts tx discard, sets tx block flag, optional error-queue copy.
// - One setting limits flags and copies to continuity PDUs or all PDUs.
// - Receive: only Y.1731 kind is validated; other kinds are data.
// - Level above endpoint: discard if block-high set, else handle as data.
// - Continuity PDU with zero period discarded; last result, change flag, irq, copy.
// - Level equal to endpoint level proceeds to destination MAC check.
// - Level below endpoint level blocked, low-block flag set, optional copy.
// - Continuity PDUs store low-level result, change flag, irq; level discards counted.
// - Destination MAC checked against multicast or unicast; failure blocks, flags, copies.
// - No version check for link trace, generic or unknown opcodes.
// - Version checked against per-PDU accepted set; mismatch blocks, flags, copies.
// - After version: continuity checked further, synthetic loss forwarded, rest valid.
// - 48-byte group id compared; last result, change flag, irq, discard, copy, count.
// - Endpoint id compared to peer; last result, change flag, irq, discard, copy, count.
// - Continuity PDU passing id checks is valid and clears loss-of-continuity.
// - Period, priority and extra TLV checks never discard.
// - Period compared; last result, change flag, irq, continuity copy, counted.
// - Priority compared; last result, change flag, irq, continuity copy.
// - Extra or nonzero end TLV sets flag; continuity copy once until re-armed.
// - Every receive discard increments the rx discard counter.
`timescale 1ns/1ps
`include "oam_pdu_validation_defines.vh"
module oam_pdu_validation (
  input wire pclk,
  input wire presetn,
  input wire [7:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output reg pslverr,
  input wire lk_valid,
  input wire lk_tx,
  input wire level_bypass_flag,
  input wire [1:0] frame_kind_field,
  input wire [2:0] lk_level,
  input wire [7:0] lk_opcode,
  input wire lk_opcode_generic,
  input wire [4:0] lk_version,
  input wire [47:0] lk_dmac,
  input wire [383:0] lk_group_id,
  input wire [12:0] lk_endpoint_id,
  input wire [2:0] lk_period,
  input wire [2:0] lk_priority,
  input wire lk_extra_tlv,
  output reg res_valid,
  output reg res_as_data,
  output reg res_pdu_ok,
  output reg res_synlm,
  output reg res_discard,
  output reg res_copy_error_queue,
  output reg res_copy_continuity_queue,
  output reg res_loc_clear,
  output wire irq
);
  reg [31:0] ctrl_q;
  reg [`EV_WIDTH-1:0] extract_q;
  reg [`EV_WIDTH-1:0] sticky_q;
  reg [`LAST_WIDTH-1:0] irq_en_q;
  reg [`LAST_WIDTH-1:0] last_q;
  reg [31:0] rx_discard_counter;
  reg [31:0] tx_discard_counter;
  reg [31:0] level_discard_counter;
  reg [31:0] group_id_error_counter;
  reg [31:0] endpoint_id_error_counter;
  reg [31:0] period_error_counter;
  reg [31:0] version_q;
  reg [31:0] mc_lsb_q;
  reg [15:0] mc_msb_q;
  reg [31:0] uc_lsb_q;
  reg [15:0] uc_msb_q;
  reg [31:0] group_id_mem [0:`GROUP_ID_WORDS-1];

  wire [5:0] widx = paddr[7:2];
  wire apb_wr = psel & penable & pwrite;
  wire apb_setup = psel & ~penable;
  wire is_gid = (widx >= `REG_GROUP_ID_BASE) && (widx < `REG_GROUP_ID_BASE + `GROUP_ID_WORDS);
  wire [3:0] gidx = widx[3:0];
  wire mapped = (widx <= `REG_UC_MAC_MSB) | is_gid;
  // No wait states: read data is already latched in the setup cycle
  assign pready = penable;

  wire [2:0] ep_level = ctrl_q[`CTRL_LEVEL_LSB +: 3];
  wire [2:0] expected_period = ctrl_q[`CTRL_PERIOD_LSB +: 3];
  wire [2:0] expected_priority = ctrl_q[`CTRL_PRIORITY_LSB +: 3];
  wire [12:0] peer_endpoint_id = ctrl_q[`CTRL_PEER_ID_LSB +: 13];
  wire dest_mac_check_select = ctrl_q[`CTRL_DMAC_SEL];
  wire error_report_continuity_only = ctrl_q[`CTRL_CONT_ONLY];

  // Per-word group id compare
  wire [`GROUP_ID_WORDS-1:0] gid_hit;
  genvar g;
  generate
    for (g = 0; g < `GROUP_ID_WORDS; g = g + 1) begin : gid_cmp
      assign gid_hit[g] = lk_group_id[g*32 +: 32] == group_id_mem[g];
    end
  endgenerate
  wire group_id_ok = &gid_hit;

  function [2:0] version_class;
    input [7:0] op;
    begin
      case (op)
        `OP_CCM: version_class = `CLS_CCM;
        `OP_LBM, `OP_LBR: version_class = `CLS_LB;
        `OP_AIS, `OP_LCK: version_class = `CLS_ALARM;
        `OP_TST: version_class = `CLS_TST;
        `OP_LMM, `OP_LMR: version_class = `CLS_LM;
        `OP_1DM, `OP_DMM, `OP_DMR: version_class = `CLS_DM;
        `OP_1SL, `OP_SLM, `OP_SLR: version_class = `CLS_SL;
        default: version_class = `CLS_NONE;
      endcase
    end
  endfunction

  wire [2:0] cls = version_class(lk_opcode);
  // Generic configuration overrides the hardware classification
  wire known = (cls != `CLS_NONE) & ~lk_opcode_generic;
  wire is_ccm = (cls == `CLS_CCM) & ~lk_opcode_generic;
  wire is_sl = (cls == `CLS_SL) & ~lk_opcode_generic;
  // Only four versions per class fit the accepted set, so higher versions always fail
  wire version_ok = (lk_version < 5'h04) & version_q[{cls, lk_version[1:0]}];
  wire dest_mac_ok = dest_mac_check_select ? (lk_dmac == {uc_msb_q, uc_lsb_q}) :
                     (lk_dmac == {mc_msb_q, mc_lsb_q});
  // Zero-period and identifier errors are copied regardless of this setting
  wire report = ~error_report_continuity_only | is_ccm;
  wire gid_check = is_ccm & ctrl_q[`CTRL_CCM_EN] & ctrl_q[`CTRL_GROUP_ID_EN];
  wire ep_check = is_ccm & ctrl_q[`CTRL_CCM_EN] & ctrl_q[`CTRL_ENDPOINT_ID_EN];

  reg as_data_d, ok_d, syn_d, disc_d, cp_err_d, cp_cc_d, loc_d;
  reg inc_lvl, inc_gid, inc_ep, inc_per, tlv_disarm;
  reg [`EV_WIDTH-1:0] ev_set;
  reg [`LAST_WIDTH-1:0] last_d;

  always @* begin
    as_data_d = 1'b0;
    ok_d = 1'b0;
    syn_d = 1'b0;
    disc_d = 1'b0;
    cp_err_d = 1'b0;
    cp_cc_d = 1'b0;
    loc_d = 1'b0;
    inc_lvl = 1'b0;
    inc_gid = 1'b0;
    inc_ep = 1'b0;
    inc_per = 1'b0;
    tlv_disarm = 1'b0;
    ev_set = {`EV_WIDTH{1'b0}};
    last_d = last_q;
    if (lk_valid) begin
      if (level_bypass_flag || frame_kind_field != `KIND_Y1731) begin
        as_data_d = 1'b1;
      end else if (lk_tx) begin
        // Transmit filtering rejects PDUs below the endpoint level
        if (lk_level < ep_level) begin
          disc_d = 1'b1;
          if (report) begin
            ev_set[`EV_TX_BLOCK] = 1'b1;
            cp_err_d = extract_q[`EV_TX_BLOCK];
          end
        end else begin
          ok_d = 1'b1;
        end
      end else if (lk_level > ep_level) begin
        // A high-level PDU is not a low-level failure, so the stored result clears
        if (is_ccm)
          last_d[`EV_LOW_LEVEL] = 1'b0;
        if (ctrl_q[`CTRL_BLOCK_HIGH]) begin
          disc_d = 1'b1;
          inc_lvl = is_ccm;
          if (report) begin
            ev_set[`EV_HIGH_BLOCK] = 1'b1;
            cp_err_d = extract_q[`EV_HIGH_BLOCK];
          end
        end else begin
          as_data_d = 1'b1;
        end
      end else begin
        if (is_ccm) begin
          last_d[`EV_ZERO_PERIOD] = lk_period == 3'h0;
          last_d[`EV_LOW_LEVEL] = lk_level < ep_level;
        end
        if (is_ccm && lk_period == 3'h0) begin
          disc_d = 1'b1;
          cp_err_d = extract_q[`EV_ZERO_PERIOD];
        end else if (lk_level < ep_level) begin
          disc_d = 1'b1;
          inc_lvl = is_ccm;
          if (report) begin
            ev_set[`EV_LOW_BLOCK] = 1'b1;
            cp_err_d = extract_q[`EV_LOW_LEVEL];
          end
        end else if (!dest_mac_ok) begin
          disc_d = 1'b1;
          if (report) begin
            ev_set[`EV_DEST_MAC] = 1'b1;
            cp_err_d = extract_q[`EV_DEST_MAC];
          end
        end else if (ctrl_q[`CTRL_VERSION_EN] && known && !version_ok) begin
          disc_d = 1'b1;
          if (report) begin
            ev_set[`EV_VERSION] = 1'b1;
            cp_err_d = extract_q[`EV_VERSION];
          end
        end else begin
          if (gid_check)
            last_d[`EV_GROUP_ID] = ~group_id_ok;
          // Endpoint id result is left alone when the group id already failed
          if (ep_check && !(gid_check && !group_id_ok))
            last_d[`EV_ENDPOINT_ID] = lk_endpoint_id != peer_endpoint_id;
          if (gid_check && !group_id_ok) begin
            disc_d = 1'b1;
            inc_gid = 1'b1;
            cp_err_d = extract_q[`EV_GROUP_ID];
          end else if (ep_check && lk_endpoint_id != peer_endpoint_id) begin
            disc_d = 1'b1;
            inc_ep = 1'b1;
            cp_err_d = extract_q[`EV_ENDPOINT_ID];
          end else if (is_ccm) begin
            // Warnings below only flag, copy and count; the PDU stays valid
            ok_d = 1'b1;
            loc_d = 1'b1;
            last_d[`EV_PERIOD] = lk_period != expected_period;
            last_d[`EV_PRIORITY] = lk_priority != expected_priority;
            inc_per = lk_period != expected_period;
            cp_cc_d = (last_d[`EV_PERIOD] & extract_q[`EV_PERIOD]) |
                      (last_d[`EV_PRIORITY] & extract_q[`EV_PRIORITY]);
            if (lk_extra_tlv) begin
              ev_set[`EV_EXTRA_TLV] = 1'b1;
              if (extract_q[`EV_EXTRA_TLV]) begin
                cp_cc_d = 1'b1;
                tlv_disarm = 1'b1;
              end
            end
          end else begin
            syn_d = is_sl;
            ok_d = ~is_sl;
          end
        end
      end
    end
    // Change flags follow any toggle of a stored last result
    ev_set[`LAST_WIDTH-1:0] = last_d ^ last_q;
  end

  // Only the change flags of stored results can interrupt; event flags cannot
  assign irq = |(sticky_q[`LAST_WIDTH-1:0] & irq_en_q);

  // Outputs and status
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res_valid <= 1'b0;
      res_as_data <= 1'b0;
      res_pdu_ok <= 1'b0;
      res_synlm <= 1'b0;
      res_discard <= 1'b0;
      res_copy_error_queue <= 1'b0;
      res_copy_continuity_queue <= 1'b0;
      res_loc_clear <= 1'b0;
      last_q <= {`LAST_WIDTH{1'b0}};
      rx_discard_counter <= 32'h0000_0000;
      tx_discard_counter <= 32'h0000_0000;
      level_discard_counter <= 32'h0000_0000;
      group_id_error_counter <= 32'h0000_0000;
      endpoint_id_error_counter <= 32'h0000_0000;
      period_error_counter <= 32'h0000_0000;
    end else begin
      res_valid <= lk_valid;
      res_as_data <= as_data_d;
      res_pdu_ok <= ok_d;
      res_synlm <= syn_d;
      res_discard <= disc_d;
      res_copy_error_queue <= cp_err_d;
      res_copy_continuity_queue <= cp_cc_d;
      res_loc_clear <= loc_d;
      last_q <= last_d;
      // Counters wrap silently; software works with differences between reads
      if (disc_d && !lk_tx)
        rx_discard_counter <= rx_discard_counter + 32'h0000_0001;
      if (disc_d && lk_tx)
        tx_discard_counter <= tx_discard_counter + 32'h0000_0001;
      if (inc_lvl)
        level_discard_counter <= level_discard_counter + 32'h0000_0001;
      if (inc_gid)
        group_id_error_counter <= group_id_error_counter + 32'h0000_0001;
      if (inc_ep)
        endpoint_id_error_counter <= endpoint_id_error_counter + 32'h0000_0001;
      if (inc_per)
        period_error_counter <= period_error_counter + 32'h0000_0001;
    end
  end

  // Register writes; a hardware set beats a simultaneous write-one-to-clear
  integer i;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `CTRL_RESET;
      extract_q <= {`EV_WIDTH{1'b0}};
      sticky_q <= {`EV_WIDTH{1'b0}};
      irq_en_q <= {`LAST_WIDTH{1'b0}};
      version_q <= `VERSION_RESET;
      mc_lsb_q <= 32'h0000_0000;
      mc_msb_q <= 16'h0000;
      uc_lsb_q <= 32'h0000_0000;
      uc_msb_q <= 16'h0000;
      for (i = 0; i < `GROUP_ID_WORDS; i = i + 1)
        group_id_mem[i] <= 32'h0000_0000;
    end else begin
      sticky_q <= (sticky_q & ~((apb_wr && widx == `REG_STICKY) ? pwdata[`EV_WIDTH-1:0] :
                  {`EV_WIDTH{1'b0}})) | ev_set;
      // One-shot TLV copy disarms itself; a software write re-arms and wins
      if (apb_wr && widx == `REG_EXTRACT)
        extract_q <= pwdata[`EV_WIDTH-1:0];
      else if (tlv_disarm)
        extract_q[`EV_EXTRA_TLV] <= 1'b0;
      if (apb_wr) begin
        case (widx)
          `REG_CTRL: ctrl_q <= pwdata;
          `REG_IRQ_EN: irq_en_q <= pwdata[`LAST_WIDTH-1:0];
          `REG_VERSION: version_q <= pwdata;
          `REG_MC_MAC_LSB: mc_lsb_q <= pwdata;
          `REG_MC_MAC_MSB: mc_msb_q <= pwdata[15:0];
          `REG_UC_MAC_LSB: uc_lsb_q <= pwdata;
          `REG_UC_MAC_MSB: uc_msb_q <= pwdata[15:0];
          default: begin
            if (is_gid)
              group_id_mem[gidx] <= pwdata;
          end
        endcase
      end
    end
  end

  // Read data is captured in the setup cycle so the access phase needs no wait
  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h0000_0000;
    case (widx)
      `REG_CTRL: rd_mux = ctrl_q;
      `REG_EXTRACT: rd_mux = {{(32-`EV_WIDTH){1'b0}}, extract_q};
      `REG_STICKY: rd_mux = {{(32-`EV_WIDTH){1'b0}}, sticky_q};
      `REG_IRQ_EN: rd_mux = {{(32-`LAST_WIDTH){1'b0}}, irq_en_q};
      `REG_LAST: rd_mux = {{(32-`LAST_WIDTH){1'b0}}, last_q};
      `REG_RX_DISCARD: rd_mux = rx_discard_counter;
      `REG_TX_DISCARD: rd_mux = tx_discard_counter;
      `REG_LEVEL_DISCARD: rd_mux = level_discard_counter;
      `REG_GROUP_ID_ERR: rd_mux = group_id_error_counter;
      `REG_ENDPOINT_ID_ERR: rd_mux = endpoint_id_error_counter;
      `REG_PERIOD_ERR: rd_mux = period_error_counter;
      `REG_VERSION: rd_mux = version_q;
      `REG_MC_MAC_LSB: rd_mux = mc_lsb_q;
      `REG_MC_MAC_MSB: rd_mux = {16'h0000, mc_msb_q};
      `REG_UC_MAC_LSB: rd_mux = uc_lsb_q;
      `REG_UC_MAC_MSB: rd_mux = {16'h0000, uc_msb_q};
      default: begin
        if (is_gid)
          rd_mux = group_id_mem[gidx];
      end
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (apb_setup) begin
      prdata <= pwrite ? 32'h0000_0000 : rd_mux;
      pslverr <= ~mapped;
    end
  end
endmodule // oam_pdu_validation

// ===== oam_pdu_validation_sva.sv
// Port-level assertions for the OAM PDU validation stage
`timescale 1ns/1ps
`include "oam_pdu_validation_defines.vh"
module oam_pdu_validation_sva (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pready,
  input wire lk_valid,
  input wire lk_tx,
  input wire level_bypass_flag,
  input wire [1:0] frame_kind_field,
  input wire [7:0] lk_opcode,
  input wire res_valid,
  input wire res_as_data,
  input wire res_pdu_ok,
  input wire res_synlm,
  input wire res_discard,
  input wire res_loc_clear
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire plain_kind = lk_valid && !level_bypass_flag && frame_kind_field != 2'h1;
  wire sl_op = lk_opcode == `OP_1SL || lk_opcode == `OP_SLM || lk_opcode == `OP_SLR;
  sequence s_as_data;
    res_valid && res_as_data && !res_discard;
  endsequence
  a_answer_next: assert property (lk_valid |=> res_valid)
    else $error("lookup got no answer");
  a_no_stray: assert property (!lk_valid |=> !res_valid)
    else $error("answer without lookup");
  a_one_verdict: assert property (res_valid |-> $onehot({res_as_data, res_pdu_ok, res_synlm, res_discard}))
    else $error("verdict not unique");
  a_bypass_data: assert property (lk_valid && level_bypass_flag |=> s_as_data)
    else $error("bypassed flow not handled as data");
  a_tx_kind_data: assert property (plain_kind && lk_tx |=> s_as_data)
    else $error("tx non-PDU kind not handled as data");
  a_rx_kind_data: assert property (plain_kind && !lk_tx |=> s_as_data)
    else $error("rx non-PDU kind not handled as data");
  a_loc_valid: assert property (res_loc_clear |-> res_valid && res_pdu_ok)
    else $error("continuity clear without valid PDU");
  a_synlm_opcode: assert property (lk_valid && !sl_op |=> !res_synlm)
    else $error("synthetic loss verdict for other opcode");
  a_zero_wait: assert property (psel && penable |-> pready)
    else $error("access phase without ready");
endmodule // oam_pdu_validation_sva
bind oam_pdu_validation oam_pdu_validation_sva chk (.pclk, .presetn, .psel, .penable, .pready, .lk_valid, .lk_tx,
  .level_bypass_flag, .frame_kind_field, .lk_opcode, .res_valid, .res_as_data, .res_pdu_ok, .res_synlm,
  .res_discard, .res_loc_clear);

// ===== lookup_source.sv
// Model of the frame lookup pipeline feeding the validation stage
`timescale 1ns/1ps
module lookup_source (
  input wire pclk,
  output reg lk_valid,
  output reg lk_tx,
  output reg level_bypass_flag,
  output reg [1:0] frame_kind_field,
  output reg [2:0] lk_level,
  output reg [7:0] lk_opcode,
  output reg lk_opcode_generic,
  output reg [4:0] lk_version,
  output reg [47:0] lk_dmac,
  output reg [383:0] lk_group_id,
  output reg [12:0] lk_endpoint_id,
  output reg [2:0] lk_period,
  output reg [2:0] lk_priority,
  output reg lk_extra_tlv
);
  // Priority and extra-TLV marker of the next lookup; the bench changes them between lookups
  reg [2:0] next_priority = 3'h5;
  reg next_extra_tlv = 1'b0;
  initial begin
    lk_valid = 1'b0;
    {lk_tx, level_bypass_flag, frame_kind_field, lk_level, lk_opcode, lk_opcode_generic} = 16'h0;
    {lk_version, lk_dmac, lk_group_id, lk_endpoint_id, lk_period, lk_priority, lk_extra_tlv} = 457'h0;
  end
  task send(input tx, input bp, input [1:0] kind, input [2:0] lvl, input [7:0] op, input [4:0] ver,
    input [47:0] dmac, input [31:0] gid, input [12:0] mep, input [2:0] per);
    begin
      @(posedge pclk);
      lk_valid <= 1'b1;
      {lk_tx, level_bypass_flag, frame_kind_field, lk_level, lk_opcode, lk_opcode_generic} <=
        {tx, bp, kind, lvl, op, 1'b0};
      {lk_version, lk_dmac, lk_group_id, lk_endpoint_id, lk_period, lk_priority, lk_extra_tlv} <=
        {ver, dmac, 352'h0, gid, mep, per, next_priority, next_extra_tlv};
      @(posedge pclk);
      lk_valid <= 1'b0;
      // Fields mean nothing between lookups, so stale values are inverted rather than held
      {lk_tx, level_bypass_flag, frame_kind_field, lk_level, lk_opcode, lk_opcode_generic} <=
        ~{lk_tx, level_bypass_flag, frame_kind_field, lk_level, lk_opcode, lk_opcode_generic};
      {lk_version, lk_dmac, lk_group_id, lk_endpoint_id, lk_period, lk_priority, lk_extra_tlv} <=
        ~{lk_version, lk_dmac, lk_group_id, lk_endpoint_id, lk_period, lk_priority, lk_extra_tlv};
    end
  endtask
endmodule // lookup_source

// ===== tb_oam_pdu_validation.sv
// Testbench for the OAM PDU validation stage
`timescale 1ns/1ps
`include "oam_pdu_validation_defines.vh"
module tb_oam_pdu_validation;
  localparam [47:0] MC_MAC = 48'h0180_C200_0030;
  localparam [31:0] CTRL_BASE = 32'h0005_B3A3;
  localparam [5:0] V_DATA = 6'h20, V_OK = 6'h10, V_LOC = 6'h11, V_SYN = 6'h08, V_DROP = 6'h06, V_DROPN = 6'h04;
  reg pclk = 1'b0;
  reg presetn = 1'b0;
  reg [7:0] paddr = 8'h00;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [31:0] pwdata = 32'h0;
  wire [31:0] prdata;
  wire pready, pslverr, irq, lk_valid, lk_tx, level_bypass_flag, lk_opcode_generic, lk_extra_tlv;
  wire [1:0] frame_kind_field;
  wire [2:0] lk_level, lk_period, lk_priority;
  wire [7:0] lk_opcode;
  wire [4:0] lk_version;
  wire [47:0] lk_dmac;
  wire [383:0] lk_group_id;
  wire [12:0] lk_endpoint_id;
  wire res_valid, res_as_data, res_pdu_ok, res_synlm, res_discard;
  wire res_copy_error_queue, res_copy_continuity_queue, res_loc_clear;
  integer err_count = 0;
  integer n_compared = 0;
  reg [31:0] rd;
  reg rd_err;
  always #2 pclk = ~pclk;
  lookup_source src (.pclk, .lk_valid, .lk_tx, .level_bypass_flag, .frame_kind_field, .lk_level, .lk_opcode,
    .lk_opcode_generic, .lk_version, .lk_dmac, .lk_group_id, .lk_endpoint_id, .lk_period, .lk_priority, .lk_extra_tlv);
  oam_pdu_validation uut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .lk_valid, .lk_tx, .level_bypass_flag, .frame_kind_field, .lk_level, .lk_opcode, .lk_opcode_generic,
    .lk_version, .lk_dmac, .lk_group_id, .lk_endpoint_id, .lk_period, .lk_priority, .lk_extra_tlv, .res_valid,
    .res_as_data, .res_pdu_ok, .res_synlm, .res_discard, .res_copy_error_queue,
    .res_copy_continuity_queue, .res_loc_clear, .irq);
  task finish_test;
    begin
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  task check(input [31:0] got, input [31:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("FAIL t=%0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task apb(input wr, input [7:0] a, input [31:0] d);
    integer n;
    begin
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= wr;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 50) begin
        n = n + 1;
        @(posedge pclk);
      end
      if (n == 50) begin
        err_count = err_count + 1;
        finish_test;
      end
      rd = prdata;
      rd_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task rdchk(input [7:0] a, input [31:0] exp);
    begin
      apb(1'b0, a, 32'h0);
      check(rd, exp);
    end
  endtask
  // Verdict bits: as_data, pdu_ok, synlm, discard, error-queue copy, continuity clear
  task look(input tx, input bp, input [1:0] kind, input [2:0] lvl, input [7:0] op, input [4:0] ver,
    input dm_ok, input [31:0] gid, input [12:0] mep, input [2:0] per, input [5:0] exp);
    begin
      src.send(tx, bp, kind, lvl, op, ver, dm_ok ? MC_MAC : ~MC_MAC, gid, mep, per);
      #1;
      check({25'h0, res_valid, res_as_data, res_pdu_ok, res_synlm, res_discard, res_copy_error_queue,
        res_loc_clear}, {25'h0, 1'b1, exp});
    end
  endtask
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(8'h00, `CTRL_RESET);
    rdchk(8'h2C, `VERSION_RESET);
    rdchk(8'h70, 32'h0);
    check({31'h0, rd_err}, 32'h1);
    apb(1'b1, 8'h30, MC_MAC[31:0]);
    apb(1'b1, 8'h34, {16'h0, MC_MAC[47:32]});
    apb(1'b1, 8'h04, 32'h0000_0FFF);
    apb(1'b1, 8'h00, CTRL_BASE);
    $display("register test done");
    look(1, 1, 1, 3, `OP_CCM, 0, 1, 0, 5, 4, V_DATA);
    look(1, 0, 2, 3, `OP_LBM, 0, 1, 0, 5, 4, V_DATA);
    look(1, 0, 1, 2, `OP_LBM, 0, 1, 0, 5, 4, V_DROP);
    look(1, 0, 1, 3, `OP_LBM, 0, 1, 0, 5, 4, V_OK);
    look(0, 0, 0, 3, `OP_CCM, 0, 1, 0, 5, 4, V_DATA);
    look(0, 0, 3, 3, `OP_CCM, 0, 1, 0, 5, 4, V_DATA);
    look(0, 0, 1, 5, `OP_LBM, 0, 1, 0, 5, 4, V_DATA);
    look(0, 0, 1, 3, `OP_CCM, 0, 1, 0, 5, 0, V_DROP);
    look(0, 0, 1, 1, `OP_CCM, 0, 1, 0, 5, 4, V_DROP);
    look(0, 0, 1, 3, `OP_LBM, 0, 0, 0, 5, 4, V_DROP);
    look(0, 0, 1, 3, 8'h05, 3, 1, 0, 5, 4, V_OK);
    look(0, 0, 1, 3, `OP_LBM, 1, 1, 0, 5, 4, V_DROP);
    look(0, 0, 1, 3, `OP_SLM, 0, 1, 0, 5, 4, V_SYN);
    look(0, 0, 1, 3, `OP_CCM, 0, 1, 1, 5, 4, V_DROP);
    look(0, 0, 1, 3, `OP_CCM, 0, 1, 0, 6, 4, V_DROP);
    look(0, 0, 1, 3, `OP_CCM, 0, 1, 0, 5, 3, V_LOC);
    check({31'h0, res_copy_continuity_queue}, 32'h1);
    look(0, 0, 1, 3, `OP_CCM, 0, 1, 0, 5, 4, V_LOC);
    check({31'h0, res_copy_continuity_queue}, 32'h0);
    src.next_priority = 3'h2;
    look(0, 0, 1, 3, `OP_CCM, 0, 1, 0, 5, 4, V_LOC);
    check({31'h0, res_copy_continuity_queue}, 32'h1);
    src.next_priority = 3'h5;
    src.next_extra_tlv = 1'b1;
    look(0, 0, 1, 3, `OP_CCM, 0, 1, 0, 5, 4, V_LOC);
    check({31'h0, res_copy_continuity_queue}, 32'h1);
    look(0, 0, 1, 3, `OP_CCM, 0, 1, 0, 5, 4, V_LOC);
    check({31'h0, res_copy_continuity_queue}, 32'h0);
    src.next_extra_tlv = 1'b0;
    apb(1'b1, 8'h00, CTRL_BASE | 32'h8);
    look(0, 0, 1, 5, `OP_LBM, 0, 1, 0, 5, 4, V_DROP);
    apb(1'b1, 8'h00, CTRL_BASE | 32'h48);
    look(0, 0, 1, 3, `OP_LBM, 0, 0, 0, 5, 4, V_DROPN);
    $display("lookup test done");
    rdchk(8'h14, 32'h8);
    rdchk(8'h18, 32'h1);
    rdchk(8'h1C, 32'h1);
    rdchk(8'h20, 32'h1);
    rdchk(8'h24, 32'h1);
    rdchk(8'h28, 32'h1);
    rdchk(8'h08, 32'h0000_0FFF);
    rdchk(8'h04, 32'h0000_07FF);
    apb(1'b1, 8'h0C, 32'h0000_003F);
    rdchk(8'h0C, 32'h0000_003F);
    check({31'h0, irq}, 32'h1);
    apb(1'b1, 8'h08, 32'h0000_0FFF);
    rdchk(8'h08, 32'h0);
    check({31'h0, irq}, 32'h0);
    $display("counter test done");
    finish_test;
  end
endmodule // tb_oam_pdu_validation
